// ==== verilog/quasi_bidir_port_mux.v ====
// Quasi-bidirectional main port, special port and function select logic
`timescale 1ns/1ps
`include "gpio_map.vh"

module quasi_bidir_port_mux (
  // Clock and resets
  input wire SYS_CLK,
  input wire RST,
  input wire PERIPH_RST,
  // Register port
  input wire [31:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  // Main port pins
  input wire [15:0] MAIN_PIN_IN,
  output wire [15:0] MAIN_PIN_OUT,
  output wire [15:0] MAIN_PIN_OE,
  output wire [15:0] MAIN_WEAK_PU,
  // Special port pins
  input wire [7:0] SPEC_PIN_IN,
  output wire [7:0] SPEC_PIN_OUT,
  output wire [7:0] SPEC_PIN_OE,
  output wire [7:0] SPEC_WEAK_PU,
  // Bus width select pin
  input wire BUS_WIDTH_SELECT_PIN,
  // Alternate functions, main port
  input wire [15:0] MAIN_ALT_OUT,
  input wire [15:0] MAIN_ALT_OE,
  output wire [15:0] MAIN_ALT_IN,
  // Alternate functions, special port
  input wire [7:0] SPEC_ALT_OUT,
  input wire [7:0] SPEC_ALT_OE,
  output wire [7:0] SPEC_ALT_IN,
  output reg NONMASKABLE_INTERRUPT_INPUT
);

  // ****************************************
  // Registers
  // ****************************************
  reg [7:0] main_sel_q;
  reg [7:0] main_latch_lo_q;
  reg [7:0] main_latch_hi_q;
  reg [7:0] spec_sel_q;
  reg [7:0] spec_latch_q;
  reg [23:0] sync1_q;
  reg [23:0] sync2_q;
  reg bsize1_q;
  reg bsize2_q;
  reg [23:0] drive_q;
  reg [23:0] oe_q;
  reg [23:0] weak_q;
  reg [23:0] drive_d;
  reg [23:0] oe_d;
  reg [23:0] weak_d;
  reg [7:0] rdata_d;

  wire [23:0] sel;
  wire [23:0] latch;
  wire [23:0] alt_out;
  wire [23:0] alt_oe;

  // ****************************************
  // Pin and strap synchronisers
  // ****************************************
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      sync1_q <= 24'h00_0000;
      sync2_q <= 24'h00_0000;
      bsize1_q <= 1'b0;
      bsize2_q <= 1'b0;
    end else begin
      sync1_q <= {SPEC_PIN_IN, MAIN_PIN_IN};
      sync2_q <= sync1_q;
      bsize1_q <= BUS_WIDTH_SELECT_PIN;
      bsize2_q <= bsize1_q;
    end
  end

  // Every alternate sees the pin, bracketed parallel inputs included
  assign MAIN_ALT_IN = sync2_q[15:0];
  assign SPEC_ALT_IN = sync2_q[23:16];

  // ****************************************
  // Control and latch registers
  // ****************************************
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      main_sel_q <= `MAIN_SEL_RST;
    end else if (WR && ADDR == `MAIN_SEL_ADDR) begin
      main_sel_q <= WDATA;
    end
  end

  // Peripheral reset leaves main select alone
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      main_latch_lo_q <= `LATCH_RST;
      main_latch_hi_q <= `LATCH_RST;
      spec_sel_q <= `SPEC_SEL_RST;
      spec_latch_q <= `LATCH_RST;
    end else if (PERIPH_RST) begin
      main_latch_lo_q <= `LATCH_RST;
      main_latch_hi_q <= `LATCH_RST;
      spec_sel_q <= `SPEC_SEL_RST;
      spec_latch_q <= `LATCH_RST;
    end else if (WR) begin
      if (ADDR == `MAIN_LATCH_LO_ADDR) begin
        main_latch_lo_q <= WDATA;
      end
      if (ADDR == `MAIN_LATCH_HI_ADDR) begin
        main_latch_hi_q <= WDATA;
      end
      if (ADDR == `SPEC_SEL_ADDR) begin
        spec_sel_q <= WDATA;
      end
      if (ADDR == `SPEC_LATCH_ADDR) begin
        spec_latch_q <= WDATA;
      end
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  assign sel = {spec_sel_q, main_sel_q, {8{bsize2_q}}};
  assign latch = {spec_latch_q, main_latch_hi_q, main_latch_lo_q};
  assign alt_out = {SPEC_ALT_OUT, MAIN_ALT_OUT};
  assign alt_oe = {SPEC_ALT_OE, MAIN_ALT_OE};

  genvar i;
  generate
    for (i = 0; i < `PIN_COUNT; i = i + 1) begin : g_pin
      always @* begin
        if (sel[i]) begin
          drive_d[i] = alt_out[i];
          oe_d[i] = alt_oe[i];
          weak_d[i] = 1'b0;
        end else begin
          drive_d[i] = latch[i];
          // Strong drive for low, or for the first cycle of a rise
          oe_d[i] = ~latch[i] | ~drive_q[i];
          weak_d[i] = latch[i];
        end
      end
    end
  endgenerate

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      drive_q <= `DRIVE_RST;
      oe_q <= `OE_RST;
      weak_q <= `WEAK_RST;
      NONMASKABLE_INTERRUPT_INPUT <= 1'b1;
    end else begin
      drive_q <= drive_d;
      oe_q <= oe_d;
      weak_q <= weak_d;
      // Active low; idle high while the line is a port pin
      NONMASKABLE_INTERRUPT_INPUT <= ~spec_sel_q[`SPEC_NMI_BIT] |
        sync2_q[`SPEC_BASE + `SPEC_NMI_BIT];
    end
  end

  assign MAIN_PIN_OUT = drive_q[15:0];
  assign MAIN_PIN_OE = oe_q[15:0];
  assign MAIN_WEAK_PU = weak_q[15:0];
  assign SPEC_PIN_OUT = drive_q[23:16];
  assign SPEC_PIN_OE = oe_q[23:16];
  assign SPEC_WEAK_PU = weak_q[23:16];

  // ****************************************
  // Read port
  // ****************************************
  always @* begin
    rdata_d = 8'h00;
    if (RD) begin
      case (ADDR)
        `MAIN_SEL_ADDR: rdata_d = main_sel_q;
        `MAIN_LATCH_LO_ADDR: rdata_d = main_latch_lo_q;
        `MAIN_LATCH_HI_ADDR: rdata_d = main_latch_hi_q;
        `MAIN_PIN_RD_LO_ADDR: rdata_d = sync2_q[7:0];
        `MAIN_PIN_RD_HI_ADDR: rdata_d = sync2_q[15:8];
        `SPEC_SEL_ADDR: rdata_d = spec_sel_q;
        `SPEC_LATCH_ADDR: rdata_d = spec_latch_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= rdata_d;
    end
  end

endmodule

// ==== verilog/gpio_map.vh ====
// Register map, reset values and field layout of the port block
`ifndef GPIO_MAP_VH
`define GPIO_MAP_VH

// Register byte addresses
`define SPEC_SEL_ADDR 32'hFFFF_8109
`define SPEC_LATCH_ADDR 32'hFFFF_810B
`define MAIN_SEL_ADDR 32'hFFFF_8503
`define MAIN_LATCH_LO_ADDR 32'hFFFF_8505
`define MAIN_LATCH_HI_ADDR 32'hFFFF_8509
`define MAIN_PIN_RD_LO_ADDR 32'hFFFF_8507
`define MAIN_PIN_RD_HI_ADDR 32'hFFFF_850B

// Reset values
`define MAIN_SEL_RST 8'h00
`define SPEC_SEL_RST 8'h80
`define LATCH_RST 8'hFF
`define DRIVE_RST 24'hFF_FFFF
`define OE_RST 24'h00_0000
`define WEAK_RST 24'h7F_FFFF

// Field positions
`define SPEC_NMI_BIT 7
`define PIN_COUNT 24
`define SPEC_BASE 16

`endif

// ==== test/quasi_bidir_port_mux_properties.sv ====
// Port block assertions
`timescale 1ns/1ps
module quasi_bidir_port_mux_properties (
  // Watched ports
  input wire SYS_CLK, RST, PERIPH_RST, WR, RD, BUS_WIDTH_SELECT_PIN,
  input wire [31:0] ADDR,
  input wire [7:0] WDATA, RDATA, SPEC_PIN_OUT,
  input wire [15:0] MAIN_PIN_IN, MAIN_PIN_OUT, MAIN_PIN_OE, MAIN_WEAK_PU
);
  // ********
  // Checks
  // ********
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  sequence calm; $stable(MAIN_PIN_IN)[*3]; endsequence
  sequence wr_hi; WR && ADDR == 32'hFFFF_8509 && !PERIPH_RST; endsequence
  sequence wr_lo;
    (!BUS_WIDTH_SELECT_PIN)[*3] ##0 (WR && ADDR == 32'hFFFF_8505 && !PERIPH_RST);
  endsequence
  AST_IDLE_RD: assert property (!RD |=> RDATA == 8'h00) else $error("idle rdata");
  AST_UNMAPPED: assert property (RD && ADDR == 32'hFFFF_8501 |=> RDATA == 8'h00)
    else $error("unmapped read");
  AST_PIN_RD: assert property (calm ##0 (RD && ADDR == 32'hFFFF_850B)
    |=> RDATA == $past(MAIN_PIN_IN[15:8])) else $error("pin read");
  AST_BACK: assert property (wr_hi ##1 (RD && ADDR == 32'hFFFF_8509)
    |=> RDATA == $past(WDATA, 2)) else $error("latch readback");
  AST_TO_PIN: assert property (wr_lo ##1 (!BUS_WIDTH_SELECT_PIN && !PERIPH_RST)
    |=> MAIN_PIN_OUT[7:0] == $past(WDATA, 2)) else $error("latch to pin");
  AST_STRONG: assert property (MAIN_PIN_OE[8] && MAIN_PIN_OUT[8] && MAIN_WEAK_PU[8]
    |=> !(MAIN_PIN_OE[8] && MAIN_WEAK_PU[8])) else $error("long strong pull");
  AST_WEAK: assert property ((MAIN_WEAK_PU & ~MAIN_PIN_OUT) == 16'h0000)
    else $error("weak on low");
  AST_SP_RST: assert property (PERIPH_RST |-> ##2 SPEC_PIN_OUT[6:0] == 7'h7F)
    else $error("special reset");
endmodule
bind quasi_bidir_port_mux quasi_bidir_port_mux_properties chk_i (.*);

// ==== test/pin_world.sv ====
// Pin-side model: drivers, pull-ups and outside sources
`timescale 1ns/1ps
module pin_world (
  // Block drive
  input wire [23:0] out_v, oe_v, pu_v,
  // Outside sources
  input wire [23:0] ext_en, ext_v,
  // Pin levels
  output wire [23:0] lvl
);
  // Outside source beats weak pull-up
  assign lvl = oe_v & out_v | ~oe_v & (ext_en & ext_v | ~ext_en & pu_v);
endmodule

// ==== test/quasi_bidir_port_mux_tb_top.sv ====
// Bench for the port block
`timescale 1ns/1ps
module quasi_bidir_port_mux_tb_top;
  logic SYS_CLK = 0, RST = 1, PERIPH_RST = 0, WR = 0, RD = 0, BUS_WIDTH_SELECT_PIN = 0;
  logic [31:0] ADDR = 0;
  logic [7:0] WDATA = 0, RDATA, SPEC_PIN_OUT, SPEC_PIN_OE, SPEC_WEAK_PU, SPEC_ALT_IN;
  logic [7:0] SPEC_ALT_OUT = 0, SPEC_ALT_OE = 0;
  logic [15:0] MAIN_PIN_OUT, MAIN_PIN_OE, MAIN_WEAK_PU, MAIN_ALT_IN, MAIN_ALT_OUT = 0;
  logic [15:0] MAIN_ALT_OE = 16'hFFFF;
  logic NONMASKABLE_INTERRUPT_INPUT;
  wire [15:0] MAIN_PIN_IN;
  wire [7:0] SPEC_PIN_IN;
  logic [23:0] ext_en = 0, ext_v = 0;
  logic [15:0] ra [6] = '{16'h8503, 16'h8505, 16'h8509, 16'h8109, 16'h810B, 16'h8501};
  logic [7:0] rr [6] = '{8'h00, 8'hFF, 8'hFF, 8'h80, 8'hFF, 8'h00};
  logic [7:0] rw [6] = '{8'hA5, 8'h3C, 8'hC3, 8'h5A, 8'h96, 8'h77};
  int miscompares = 0, samples_checked = 0;
  always #25 SYS_CLK = ~SYS_CLK;
  quasi_bidir_port_mux quasi_bidir_port_mux_i (.*);
  pin_world pin_world_i (.out_v({SPEC_PIN_OUT, MAIN_PIN_OUT}), .oe_v({SPEC_PIN_OE, MAIN_PIN_OE}),
    .pu_v({SPEC_WEAK_PU, MAIN_WEAK_PU}), .ext_en(ext_en), .ext_v(ext_v),
    .lvl({SPEC_PIN_IN, MAIN_PIN_IN}));
  // ********
  // Tasks
  // ********
  task chk(input logic [7:0] s, e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t seen %h want %h", $time, s, e);
    end
  endtask
  task wr_reg(input logic [15:0] a, input logic [7:0] d);
    ADDR <= {16'hFFFF, a};
    WDATA <= d;
    WR <= 1;
    @(posedge SYS_CLK);
    WR <= 0;
  endtask
  task rd_reg(input logic [15:0] a, input logic [7:0] e);
    ADDR <= {16'hFFFF, a};
    RD <= 1;
    @(posedge SYS_CLK);
    RD <= 0;
    #1 chk(RDATA, e);
    @(posedge SYS_CLK);
  endtask
  task give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ********
  // Tests
  // ********
  initial begin
    #100000;
    miscompares++;
    give_verdict;
  end
  initial begin
    repeat (16) @(posedge SYS_CLK);
    RST <= 0;
    @(posedge SYS_CLK);
    for (int i = 0; i < 6; i++) begin
      rd_reg(ra[i], rr[i]);
      wr_reg(ra[i], rw[i]);
      rd_reg(ra[i], i == 5 ? 8'h00 : rw[i]);
    end
    repeat (3) @(posedge SYS_CLK);
    chk(MAIN_PIN_OUT[15:8], 8'h42);
    chk(MAIN_PIN_OUT[7:0], 8'h3C);
    BUS_WIDTH_SELECT_PIN <= 1;
    repeat (4) @(posedge SYS_CLK);
    chk(MAIN_PIN_OUT[7:0], 8'h00);
    BUS_WIDTH_SELECT_PIN <= 0;
    $display("map done");
    wr_reg(16'h8503, 8'h00);
    wr_reg(16'h8509, 8'h00);
    wr_reg(16'h8509, 8'h01);
    @(posedge SYS_CLK);
    #1 chk({5'h00, MAIN_PIN_OE[8], MAIN_PIN_OUT[8], MAIN_WEAK_PU[8]}, 8'h07);
    @(posedge SYS_CLK);
    #1 chk({5'h00, MAIN_PIN_OE[8], MAIN_PIN_OUT[8], MAIN_WEAK_PU[8]}, 8'h03);
    @(posedge SYS_CLK);
    wr_reg(16'h8509, 8'hFF);
    ext_en <= 24'h00_1000;
    repeat (6) @(posedge SYS_CLK);
    rd_reg(16'h850B, 8'hEF);
    rd_reg(16'h8509, 8'hFF);
    rd_reg(16'h8507, 8'h3C);
    chk(MAIN_ALT_IN[15:8], 8'hEF);
    $display("pins done");
    wr_reg(16'h8503, 8'h3C);
    PERIPH_RST <= 1;
    @(posedge SYS_CLK);
    PERIPH_RST <= 0;
    rd_reg(16'h8503, 8'h3C);
    rd_reg(16'h8109, 8'h80);
    rd_reg(16'h810B, 8'hFF);
    rd_reg(16'h8505, 8'hFF);
    ext_en <= 24'h80_0000;
    ext_v <= 24'h80_0000;
    repeat (4) @(posedge SYS_CLK);
    chk({7'h00, NONMASKABLE_INTERRUPT_INPUT}, 8'h01);
    chk({7'h00, SPEC_ALT_IN[7]}, 8'h01);
    ext_v <= 24'h00_0000;
    repeat (4) @(posedge SYS_CLK);
    chk({7'h00, NONMASKABLE_INTERRUPT_INPUT}, 8'h00);
    RST <= 1;
    @(posedge SYS_CLK);
    RST <= 0;
    @(posedge SYS_CLK);
    rd_reg(16'h8503, 8'h00);
    rd_reg(16'h8109, 8'h80);
    $display("reset done");
    give_verdict;
  end
endmodule
